// *** ccr_alu_flags.sv ***
// Adder and subtractor with the status flags it produces.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ps
module ccr_alu_flags (
  input  wire logic [7:0] i_a,                 // Accumulator operand
  input  wire logic [7:0] i_b,                 // Second operand
  input  wire logic       i_cin,               // Carry or borrow in
  input  wire logic       i_sub,               // High for subtract
  output logic      [7:0] o_res,               // Result
  output logic            o_cy,                // Carry, or not-borrow
  output logic            o_ac,                // Aux carry
  output logic            o_ov                 // Signed overflow
);

  logic [8:0] full;
  logic [4:0] low;
  logic [7:0] bx;

  always_comb begin
    bx    = i_sub ? ~i_b : i_b;
    full  = {1'b0, i_a} + {1'b0, bx} + {8'h00, i_sub ^ i_cin};
    low   = {1'b0, i_a[3:0]} + {1'b0, bx[3:0]} + {4'h0, i_sub ^ i_cin};
    o_res = full[7:0];
    o_cy  = full[8];
    o_ac  = low[4];
    o_ov  = (i_a[7] == bx[7]) && (full[7] != i_a[7]);
  end

endmodule : ccr_alu_flags

// *** ccr_core_regs.sv ***
// Architectural register set and memory map of the 8-bit core.
// Overview of operation
// - Stack pointer resets to 07h; incremented before each pushed byte.
// - Program counter resets to zero so fetch starts at 0000h.
// - Interrupts jump to vectors 0003h plus eight bytes per source.
// - Two status bits pick one of four eight-register banks in low RAM.
// - Carry takes adder carry or not-borrow, and shift or rotate value.
// - Aux carry from bit 3 carry, or no borrow into bit 4.
// - Overflow set when signed result leaves -128..+127.
// - Clear-overflow clears it; bit test copies operand bit 6 into it.
// - Parity bit makes ones of accumulator plus parity even.
// - Accumulator and multiply operand form one 16-bit pair.
// - Data pointer is 16 bits from high and low bytes.
// - 64KB spaces; page register is only stored and driven out on o_page, not used in addresses.
// - Flash is read-only except while programming.
// - Special registers at 80h-FFh only by direct addressing.
// - Special registers ending 0h or 8h are bit addressable, bits 80h-FFh.
// - RAM bytes 32-47 hold 128 addressable bits.
// - Display RAM via pointer and buffer; pointer post-increments.
// - Display RAM at FF00-FFFF externally; range freed when disabled.
// Assumes one request per cycle from the core sequencer on the same clock.
`timescale 1ns/1ps
module ccr_core_regs (
  input  wire logic        i_clk_sys,        // System clock, 20 MHz
  input  wire logic        i_rst_b,          // Synchronous reset, active low
  input  wire logic        i_acc_valid,      // Data-space access request
  input  wire logic        i_acc_wr,         // Access is a write
  input  wire logic [1:0]  i_acc_space,      // Direct, indirect, register, bit
  input  wire logic [7:0]  i_acc_addr,       // Address, register index or bit
  input  wire logic [7:0]  i_acc_wdata,      // Write data, bit value in bit 0
  input  wire logic        i_push,           // Push byte onto stack
  input  wire logic        i_pop,            // Pop byte from stack
  input  wire logic [7:0]  i_push_data,      // Byte to push
  input  wire logic        i_pc_inc,         // Advance program counter
  input  wire logic        i_pc_load,        // Load program counter
  input  wire logic [15:0] i_pc_value,       // Program counter load value
  input  wire logic        i_irq_take,       // Enter interrupt service
  input  wire logic [2:0]  i_irq_num,        // Interrupt source number
  input  wire logic        i_alu_valid,      // Add or subtract into accumulator
  input  wire logic        i_alu_sub,        // Subtract
  input  wire logic        i_alu_use_cy,     // Include carry flag
  input  wire logic [7:0]  i_alu_operand,    // Second operand
  input  wire logic        i_cy_we,          // Shift or rotate carry update
  input  wire logic        i_cy_val,         // New carry from shifter
  input  wire logic        i_clr_ov,         // Clear-overflow instruction
  input  wire logic        i_bit_test,       // Bit-test instruction
  input  wire logic [7:0]  i_bit_test_op,    // Bit-test memory operand
  input  wire logic        i_ab_we,          // Multiply or divide result
  input  wire logic [15:0] i_ab_value,       // Result pair, operand reg high
  input  wire logic        i_data_pointer_inc,       // Increment data pointer
  input  wire logic        i_xmov_valid,     // External-move request
  input  wire logic        i_xmov_wr,        // External-move write
  input  wire logic        i_xmov_data_pointer,      // Address from data pointer
  input  wire logic [7:0]  i_xmov_hi,        // High byte for register form
  input  wire logic [7:0]  i_xmov_lo,        // Low byte for register form
  input  wire logic [7:0]  i_xmov_wdata,     // External-move write data
  input  wire logic        i_xmem_is_flash,  // Outside decode: target is flash
  input  wire logic        i_flash_prog,     // Flash programming pin
  output logic             o_rd_valid,       // Read answer valid
  output logic      [7:0]  o_rd_data,        // Read answer data
  output logic             o_busy,           // Bit write in progress
  output logic      [15:0] o_pc,             // Program counter
  output logic      [7:0]  o_acc,            // Accumulator
  output logic      [7:0]  o_b,              // Multiply operand register
  output logic      [7:0]  o_sp,             // Stack pointer
  output logic      [7:0]  o_psw,            // Program status word
  output logic      [15:0] o_data_pointer,           // Data pointer
  output logic      [7:0]  o_page,           // Page register
  output logic             o_xmem_req,       // External memory strobe
  output logic             o_xmem_wr,        // External memory write
  output logic      [15:0] o_xmem_addr,      // External memory address
  output logic      [7:0]  o_xmem_wdata      // External memory write data
);

  typedef enum logic [1:0] {ST_IDLE, ST_BIT_WAIT} ccr_state_e;
  typedef enum logic [1:0] {SRC_HOLD, SRC_IRAM, SRC_DISP} ccr_src_e;

  typedef struct packed {
    ccr_state_e  st;
    logic        busy;
    logic [15:0] pc;
    logic [7:0]  acc;
    logic [7:0]  b;
    logic [7:0]  sp;
    logic [7:0]  program_status_word;
    logic [15:0] data_pointer;
    logic [7:0]  page;
    logic [7:0]  disp_ptr;
    logic        disp_en;
    logic        prog_s1;
    logic        prog_s2;
    logic        rd_pend;
    ccr_src_e    rd_src;
    logic        rd_is_bit;
    logic [2:0]  bit_sel;
    logic [7:0]  rd_hold;
    logic        bit_val;
    logic [7:0]  bit_byte;
    logic        rd_valid;
    logic [7:0]  rd_data;
    logic        xm_req;
    logic        xm_wr;
    logic [15:0] xm_addr;
    logic [7:0]  xm_wdata;
  } ccr_state_s;

  ccr_state_s s_q, s_d;

  logic       iram_we, disp_we;
  logic [7:0] iram_wa, iram_wd, iram_ra, iram_rd;
  logic [7:0] disp_wa, disp_wd, disp_ra, disp_rd;
  logic [7:0] alu_res;
  logic       alu_cy, alu_ac, alu_ov;
  logic [7:0] a_bank, a_bitbyte, a_sfrbit, sfr_bits;
  logic [15:0] x_addr;
  logic        x_disp;

  ccr_alu_flags u_alu (
    .i_a   (s_q.acc),
    .i_b   (i_alu_operand),
    .i_cin (i_alu_use_cy & s_q.program_status_word[ccr_pkg::PSW_CY]),
    .i_sub (i_alu_sub),
    .o_res (alu_res),
    .o_cy  (alu_cy),
    .o_ac  (alu_ac),
    .o_ov  (alu_ov)
  );

  ccr_ram #(.AW(8)) u_iram (
    .i_clk_sys (i_clk_sys),
    .i_we      (iram_we),
    .i_waddr   (iram_wa),
    .i_wdata   (iram_wd),
    .i_raddr   (iram_ra),
    .o_rdata   (iram_rd)
  );

  ccr_ram #(.AW(8)) u_disp (
    .i_clk_sys (i_clk_sys),
    .i_we      (disp_we),
    .i_waddr   (disp_wa),
    .i_wdata   (disp_wd),
    .i_raddr   (disp_ra),
    .o_rdata   (disp_rd)
  );

  function automatic logic [7:0] sfr_read(input ccr_state_s q, input logic [7:0] a,
                                          input logic [7:0] buf_rd);
    case (a)
      ccr_pkg::ADR_SP:       sfr_read = q.sp;
      ccr_pkg::ADR_DPL:      sfr_read = q.data_pointer[7:0];
      ccr_pkg::ADR_DPH:      sfr_read = q.data_pointer[15:8];
      ccr_pkg::ADR_PAGE:     sfr_read = q.page;
      ccr_pkg::ADR_DISP_PTR: sfr_read = q.disp_ptr;
      ccr_pkg::ADR_DISP_BUF: sfr_read = buf_rd;
      ccr_pkg::ADR_DISP_CTL: sfr_read = {7'h00, q.disp_en};
      ccr_pkg::ADR_PSW:      sfr_read = q.program_status_word;
      ccr_pkg::ADR_ACC:      sfr_read = q.acc;
      ccr_pkg::ADR_B:        sfr_read = q.b;
      default:               sfr_read = 8'h00;
    endcase
  endfunction : sfr_read

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    s_d      = s_q;
    iram_we  = 1'b0;
    iram_wa  = 8'h00;
    iram_wd  = 8'h00;
    iram_ra  = s_q.sp;
    disp_we  = 1'b0;
    disp_wa  = s_q.disp_ptr;
    disp_wd  = i_acc_wdata;
    a_bank   = {3'b000, s_q.program_status_word[ccr_pkg::PSW_RS_HI], s_q.program_status_word[ccr_pkg::PSW_RS_LO],
                i_acc_addr[2:0]};
    a_bitbyte = ccr_pkg::BIT_RAM_BASE | {4'h0, i_acc_addr[6:3]};
    a_sfrbit  = {i_acc_addr[7:3], 3'b000};
    sfr_bits  = sfr_read(s_q, a_sfrbit, disp_rd);
    x_addr   = i_xmov_data_pointer ? s_q.data_pointer : {i_xmov_hi, i_xmov_lo};
    x_disp   = s_q.disp_en && (x_addr[15:8] == ccr_pkg::DISP_WIN_HI);
    s_d.prog_s1  = i_flash_prog;
    s_d.prog_s2  = s_q.prog_s1;
    s_d.rd_valid = 1'b0;
    s_d.rd_pend  = 1'b0;
    s_d.xm_req   = 1'b0;
    // Second read stage: registered RAM data or held value
    if (s_q.rd_pend) begin
      s_d.rd_valid = 1'b1;
      case (s_q.rd_src)
        SRC_IRAM: s_d.rd_data = s_q.rd_is_bit ? {7'h00, iram_rd[s_q.bit_sel]} : iram_rd;
        SRC_DISP: s_d.rd_data = disp_rd;
        default:  s_d.rd_data = s_q.rd_hold;
      endcase
    end
    case (s_q.st)
      ST_BIT_WAIT: begin
        iram_we = 1'b1;
        iram_wa = s_q.bit_byte;
        iram_wd = iram_rd;
        iram_wd[s_q.bit_sel] = s_q.bit_val;
        s_d.st  = ST_IDLE;
      end
      default: begin
        if (i_acc_valid) begin
          s_d.rd_pend   = !i_acc_wr;
          s_d.rd_src    = SRC_HOLD;
          s_d.rd_is_bit = 1'b0;
          s_d.bit_sel   = i_acc_addr[2:0];
          case (i_acc_space)
            ccr_pkg::SP_DIRECT: begin
              if (i_acc_addr >= ccr_pkg::SFR_BASE) begin
                s_d.rd_hold = sfr_read(s_q, i_acc_addr, disp_rd);
                if (i_acc_addr == ccr_pkg::ADR_DISP_BUF) begin
                  s_d.disp_ptr = s_q.disp_ptr + 8'h01;
                  disp_we      = i_acc_wr;
                end
                if (i_acc_wr) begin
                  case (i_acc_addr)
                    ccr_pkg::ADR_SP:       s_d.sp         = i_acc_wdata;
                    ccr_pkg::ADR_DPL:      s_d.data_pointer[7:0]  = i_acc_wdata;
                    ccr_pkg::ADR_DPH:      s_d.data_pointer[15:8] = i_acc_wdata;
                    ccr_pkg::ADR_PAGE:     s_d.page       = i_acc_wdata;
                    ccr_pkg::ADR_DISP_PTR: s_d.disp_ptr   = i_acc_wdata;
                    ccr_pkg::ADR_DISP_CTL: s_d.disp_en    = i_acc_wdata[0];
                    ccr_pkg::ADR_PSW:      s_d.program_status_word        = i_acc_wdata;
                    ccr_pkg::ADR_ACC:      s_d.acc        = i_acc_wdata;
                    ccr_pkg::ADR_B:        s_d.b          = i_acc_wdata;
                    default:               s_d.page       = s_q.page;
                  endcase
                end
              end else begin
                iram_ra     = i_acc_addr;
                iram_we     = i_acc_wr;
                iram_wa     = i_acc_addr;
                iram_wd     = i_acc_wdata;
                s_d.rd_src  = SRC_IRAM;
              end
            end
            ccr_pkg::SP_BIT: begin
              s_d.rd_is_bit = 1'b1;
              if (i_acc_addr[7]) begin
                s_d.rd_hold = {7'h00, sfr_bits[i_acc_addr[2:0]]};
                if (i_acc_wr) begin
                  case (a_sfrbit)
                    ccr_pkg::ADR_PSW: s_d.program_status_word[i_acc_addr[2:0]] = i_acc_wdata[0];
                    ccr_pkg::ADR_ACC: s_d.acc[i_acc_addr[2:0]] = i_acc_wdata[0];
                    ccr_pkg::ADR_B:   s_d.b[i_acc_addr[2:0]]   = i_acc_wdata[0];
                    default:          s_d.b                    = s_q.b;
                  endcase
                end
              end else begin
                iram_ra    = a_bitbyte;
                s_d.rd_src = SRC_IRAM;
                if (i_acc_wr) begin
                  s_d.st       = ST_BIT_WAIT;
                  s_d.bit_byte = a_bitbyte;
                  s_d.bit_val  = i_acc_wdata[0];
                end
              end
            end
            default: begin
              // Indirect reaches all 256 RAM bytes, never the special space
              iram_ra    = (i_acc_space == ccr_pkg::SP_REGISTER) ? a_bank : i_acc_addr;
              iram_we    = i_acc_wr;
              iram_wa    = iram_ra;
              iram_wd    = i_acc_wdata;
              s_d.rd_src = SRC_IRAM;
            end
          endcase
        end else if (i_push) begin
          s_d.sp  = s_q.sp + 8'h01;
          iram_we = 1'b1;
          iram_wa = s_q.sp + 8'h01;
          iram_wd = i_push_data;
        end else if (i_pop) begin
          iram_ra     = s_q.sp;
          s_d.sp      = s_q.sp - 8'h01;
          s_d.rd_pend = 1'b1;
          s_d.rd_src  = SRC_IRAM;
          s_d.rd_is_bit = 1'b0;
        end else if (i_xmov_valid) begin
          if (x_disp) begin
            disp_we     = i_xmov_wr;
            disp_wa     = x_addr[7:0];
            disp_wd     = i_xmov_wdata;
            s_d.rd_pend = !i_xmov_wr;
            s_d.rd_src  = SRC_DISP;
          end else begin
            s_d.xm_req   = 1'b1;
            s_d.xm_wr    = i_xmov_wr && (!i_xmem_is_flash || s_q.prog_s2);
            s_d.xm_addr  = x_addr;
            s_d.xm_wdata = i_xmov_wdata;
          end
        end
      end
    endcase
    disp_ra = (i_xmov_valid && x_disp && s_q.st == ST_IDLE && !i_acc_valid && !i_push
               && !i_pop) ? x_addr[7:0] : s_d.disp_ptr;
    // Datapath results written after register-port writes
    if (i_ab_we) begin
      s_d.b   = i_ab_value[15:8];
      s_d.acc = i_ab_value[7:0];
    end
    if (i_alu_valid) begin
      s_d.acc                   = alu_res;
      s_d.program_status_word[ccr_pkg::PSW_CY]  = alu_cy;
      s_d.program_status_word[ccr_pkg::PSW_AC]  = alu_ac;
    end
    if (i_cy_we) begin
      s_d.program_status_word[ccr_pkg::PSW_CY] = i_cy_val;
    end
    if (i_clr_ov) begin
      s_d.program_status_word[ccr_pkg::PSW_OV] = 1'b0;
    end
    if (i_bit_test) begin
      s_d.program_status_word[ccr_pkg::PSW_OV] = i_bit_test_op[6];
    end
    if (i_alu_valid) begin
      s_d.program_status_word[ccr_pkg::PSW_OV] = alu_ov;
    end
    if (i_data_pointer_inc) begin
      s_d.data_pointer = s_q.data_pointer + 16'h0001;
    end
    if (i_irq_take) begin
      s_d.pc = ccr_pkg::VEC_BASE + ({13'h0000, i_irq_num} << ccr_pkg::VEC_STEP_LOG2);
    end else if (i_pc_load) begin
      s_d.pc = i_pc_value;
    end else if (i_pc_inc) begin
      s_d.pc = s_q.pc + 16'h0001;
    end
    s_d.program_status_word[ccr_pkg::PSW_P] = ^s_d.acc;
    s_d.busy = (s_d.st == ST_BIT_WAIT);
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      s_q    <= '0;
      s_q.st <= ST_IDLE;
      s_q.sp <= ccr_pkg::SP_RST;
      s_q.pc <= ccr_pkg::PC_RST;
    end else begin
      s_q <= s_d;
    end
  end

  always_comb begin
    o_rd_valid   = s_q.rd_valid;
    o_rd_data    = s_q.rd_data;
    o_busy       = s_q.busy;
    o_pc         = s_q.pc;
    o_acc        = s_q.acc;
    o_b          = s_q.b;
    o_sp         = s_q.sp;
    o_psw        = s_q.program_status_word;
    o_data_pointer       = s_q.data_pointer;
    o_page       = s_q.page;
    o_xmem_req   = s_q.xm_req;
    o_xmem_wr    = s_q.xm_wr;
    o_xmem_addr  = s_q.xm_addr;
    o_xmem_wdata = s_q.xm_wdata;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  sequence push_req;
    i_push && !i_acc_valid && s_q.st == ST_IDLE;
  endsequence
  sequence push_done(logic [7:0] sp0);
    s_q.sp == sp0 + 8'h01;
  endsequence

  a_sp_reset: assert property (@(posedge i_clk_sys) $rose(i_rst_b) |-> o_sp == 8'h07)
    else $error("stack pointer not 07h after reset");
  a_push_preinc: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    push_req |-> iram_wa == s_q.sp + 8'h01 ##1 push_done($past(s_q.sp)))
    else $error("push did not pre-increment stack pointer");
  a_pc_reset: assert property (@(posedge i_clk_sys) $rose(i_rst_b) |-> o_pc == 16'h0000)
    else $error("program counter not zero after reset");
  a_irq_vector: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    i_irq_take |=> o_pc == 16'h0003 + 16'h0008 * $past(i_irq_num))
    else $error("interrupt vector wrong");
  a_bank_map: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    i_acc_valid && i_acc_space == ccr_pkg::SP_REGISTER && s_q.st == ST_IDLE
    |-> iram_ra[7:5] == 3'b000 && iram_ra[4:3] == o_psw[4:3])
    else $error("register bank address wrong");
  a_parity_even: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    ##1 (^{o_acc, o_psw[0]}) == 1'b0)
    else $error("parity flag does not make count even");
  a_ov_bit_test: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    i_bit_test && !i_alu_valid |=> o_psw[2] == $past(i_bit_test_op[6]))
    else $error("bit test did not copy bit 6");
  a_ov_clear: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    i_clr_ov && !i_alu_valid && !i_bit_test |=> !o_psw[2])
    else $error("overflow not cleared");
  a_flash_guard: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    s_q.st == ST_IDLE && !i_acc_valid && !i_push && !i_pop && i_xmov_valid && !x_disp
    && i_xmem_is_flash && !s_q.prog_s2 |=> !o_xmem_wr)
    else $error("flash written outside programming");
  a_disp_window: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    s_q.st == ST_IDLE && !i_acc_valid && !i_push && !i_pop && i_xmov_valid && x_disp
    |=> !o_xmem_req)
    else $error("display window leaked to external bus");

endmodule : ccr_core_regs

// *** ccr_core_regs_bench.sv ***
// Self-checking bench of the core register set.
// Assumes ccr_pkg is compiled first; inputs change on falling edges.
`timescale 1ns/1ps
module ccr_core_regs_bench;
  logic i_clk_sys = 0, i_rst_b = 0, i_acc_valid = 0, i_acc_wr = 0, i_push = 0, i_pop = 0;
  logic i_pc_inc = 0, i_pc_load = 0, i_irq_take = 0, i_alu_valid = 0, i_alu_sub = 0;
  logic i_alu_use_cy = 0, i_cy_we = 0, i_cy_val = 0, i_clr_ov = 0, i_bit_test = 0;
  logic i_ab_we = 0, i_data_pointer_inc = 0, i_xmov_valid = 0, i_xmov_wr = 0, i_xmov_data_pointer = 0;
  logic i_flash_prog = 0, i_xmem_is_flash, o_rd_valid, o_busy, o_xmem_req, o_xmem_wr;
  logic [1:0] i_acc_space = 0;
  logic [2:0] i_irq_num = 0;
  logic [7:0] i_acc_addr = 0, i_acc_wdata = 0, i_push_data = 0, i_alu_operand = 0;
  logic [7:0] i_bit_test_op = 0, i_xmov_hi = 0, i_xmov_lo = 0, i_xmov_wdata = 0, last_wr;
  logic [7:0] o_rd_data, o_acc, o_b, o_sp, o_psw, o_page, o_xmem_wdata;
  logic [15:0] i_pc_value = 0, i_ab_value = 0, o_pc, o_data_pointer, o_xmem_addr;
  int fails = 0, n_compared = 0;
  ccr_core_regs dut (.*);
  ccr_xmem_model mem (.i_clk_sys(i_clk_sys), .i_req(o_xmem_req), .i_wr(o_xmem_wr),
    .i_wdata(o_xmem_wdata), .i_dec({i_xmov_hi, i_xmov_lo}), .o_flash(i_xmem_is_flash),
    .o_last(last_wr));
  always #25 i_clk_sys = ~i_clk_sys;
  task automatic check(input string what, input logic [15:0] exp, got);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic step(); // One edge passes, then every strobe drops
    @(negedge i_clk_sys);
    {i_acc_valid, i_push, i_pop, i_pc_inc, i_pc_load, i_irq_take, i_alu_valid} = '0;
    {i_cy_we, i_clr_ov, i_bit_test, i_ab_we, i_data_pointer_inc, i_xmov_valid} = '0;
  endtask : step
  task automatic acc(input logic wr, input logic [1:0] sp, input logic [7:0] a, d);
    {i_acc_valid, i_acc_wr, i_acc_space, i_acc_addr, i_acc_wdata} = {1'b1, wr, sp, a, d};
    step();
    step(); // Leaves room for the busy cycle of a bit write
  endtask : acc
  task automatic rd(input logic [1:0] sp, input logic [7:0] a, exp);
    acc(1'b0, sp, a, 8'h00);
    check("rd_valid", 16'h0001, {15'h0, o_rd_valid});
    check("rd_data", {8'h00, exp}, {8'h00, o_rd_data});
  endtask : rd
  task automatic xmov(input logic [15:0] a, input logic [7:0] d, input logic req);
    {i_xmov_valid, i_xmov_wr, i_xmov_hi, i_xmov_lo, i_xmov_wdata} = {2'h3, a, d};
    step();
    check("xmem_req", {15'h0, req}, {15'h0, o_xmem_req});
    repeat (2) step();
  endtask : xmov
  task automatic final_report();
    $display("Compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : final_report
  initial begin
    repeat (4) @(negedge i_clk_sys);
    i_rst_b = 1'b1;
    check("sp", 16'h0007, {8'h00, o_sp});
    check("pc", 16'h0000, o_pc);
    {i_push, i_push_data} = {1'b1, 8'hA5};
    step();
    check("sp", 16'h0008, {8'h00, o_sp});
    rd(2'h0, 8'h08, 8'hA5);
    i_pop = 1'b1;
    repeat (2) step();
    check("pop", 16'h01A5, {7'h0, o_rd_valid, o_rd_data});
    for (int n = 0; n < 4; n++) begin
      {i_irq_take, i_irq_num} = {1'b1, 3'(n)};
      step();
      check("vector", 16'h0003 + 16'(8 * n), o_pc);
    end
    {i_pc_load, i_pc_value} = {1'b1, 16'hFFFF};
    step();
    i_pc_inc = 1'b1;
    step();
    check("pc", 16'h0000, o_pc);
    for (int k = 0; k < 4; k++) begin
      acc(1'b1, 2'h0, ccr_pkg::ADR_PSW, 8'(k << 3));
      acc(1'b1, 2'h2, 8'h07, 8'(8'h50 + k));
      rd(2'h0, 8'(8 * k + 7), 8'(8'h50 + k));
    end
    acc(1'b1, 2'h0, ccr_pkg::ADR_ACC, 8'h7F);
    {i_alu_valid, i_alu_operand} = {1'b1, 8'h01};
    step();
    check("psw add", 16'h805D, {o_acc, o_psw});
    i_clr_ov = 1'b1;
    step();
    check("psw", 16'h0059, {8'h00, o_psw});
    {i_bit_test, i_bit_test_op} = {1'b1, 8'h40};
    step();
    check("psw", 16'h005D, {8'h00, o_psw});
    {i_alu_valid, i_alu_sub} = 2'h3;
    step();
    check("psw sub", 16'h7F9D, {o_acc, o_psw});
    {i_cy_we, i_cy_val} = 2'h2;
    step();
    check("psw", 16'h001D, {8'h00, o_psw});
    {i_ab_we, i_ab_value} = {1'b1, 16'hBEEF};
    step();
    check("pair", 16'hBEEF, {o_b, o_acc});
    acc(1'b1, 2'h3, 8'hE0, 8'h00);
    check("acc bit", 16'h00EE, {8'h00, o_acc});
    acc(1'b1, 2'h0, 8'h2F, 8'h00);
    {i_acc_valid, i_acc_wr, i_acc_space, i_acc_addr, i_acc_wdata} = {2'h3, 2'h3, 16'h7F01};
    step();
    check("busy", 16'h0001, {15'h0, o_busy});
    step();
    rd(2'h0, 8'h2F, 8'h80);
    rd(2'h3, 8'h7F, 8'h01);
    acc(1'b1, 2'h1, 8'h90, 8'h77);
    rd(2'h1, 8'h90, 8'h77);
    rd(2'h0, 8'hC1, 8'h00);
    acc(1'b1, 2'h0, ccr_pkg::ADR_DPH, 8'h12);
    check("data_pointer", 16'h1200, o_data_pointer);
    acc(1'b1, 2'h0, ccr_pkg::ADR_PAGE, 8'h3C);
    check("page", 16'h003C, {8'h00, o_page});
    xmov(16'h1000, 8'h5A, 1'b1);
    check("xmem", 16'h015A, {7'h0, o_xmem_wr, last_wr});
    xmov(16'h8000, 8'h3C, 1'b1);
    check("flash", 16'h005A, {7'h0, o_xmem_wr, last_wr});
    check("xaddr", 16'h8000, o_xmem_addr);
    acc(1'b1, 2'h0, ccr_pkg::ADR_DISP_CTL, 8'h01);
    xmov(16'hFF10, 8'h66, 1'b0);
    check("no xmem", 16'h005A, {8'h00, last_wr});
    acc(1'b1, 2'h0, ccr_pkg::ADR_DISP_PTR, 8'h10);
    rd(2'h0, ccr_pkg::ADR_DISP_BUF, 8'h66);
    rd(2'h0, ccr_pkg::ADR_DISP_PTR, 8'h11);
    {i_pc_load, i_pc_value} = {1'b1, 16'h1234};
    step();
    i_rst_b = 1'b0;
    repeat (2) step();
    i_rst_b = 1'b1;
    check("sp", 16'h0007, {8'h00, o_sp});
    check("pc", 16'h0000, o_pc);
    final_report();
  end
endmodule : ccr_core_regs_bench

// *** ccr_pkg.sv ***
// Shared constants of the core register set: reset values, vector layout,
// special-function addresses, status-word bit positions and encodings.
// Assumes a single system clock; referenced by scope only from ccr_core_regs and its bench.
package ccr_pkg;

  // Reset values
  localparam logic [7:0]  SP_RST        = 8'h07;
  localparam logic [15:0] PC_RST        = 16'h0000;

  // Interrupt vectors: base and spacing
  localparam logic [15:0] VEC_BASE      = 16'h0003;
  localparam int          VEC_STEP_LOG2 = 3;

  // Special-function space and bit-addressable RAM area
  localparam logic [7:0]  SFR_BASE      = 8'h80;
  localparam logic [7:0]  BIT_RAM_BASE  = 8'h20;

  // Special-function register addresses
  localparam logic [7:0]  ADR_SP        = 8'h81;
  localparam logic [7:0]  ADR_DPL       = 8'h82;
  localparam logic [7:0]  ADR_DPH       = 8'h83;
  localparam logic [7:0]  ADR_PAGE      = 8'h84;
  localparam logic [7:0]  ADR_DISP_PTR  = 8'h85;
  localparam logic [7:0]  ADR_DISP_BUF  = 8'h86;
  localparam logic [7:0]  ADR_DISP_CTL  = 8'h87;
  localparam logic [7:0]  ADR_PSW       = 8'hD0;
  localparam logic [7:0]  ADR_ACC       = 8'hE0;
  localparam logic [7:0]  ADR_B         = 8'hF0;

  // Status-word bit positions
  localparam int          PSW_CY        = 7;
  localparam int          PSW_AC        = 6;
  localparam int          PSW_RS_HI     = 4;
  localparam int          PSW_RS_LO     = 3;
  localparam int          PSW_OV        = 2;
  localparam int          PSW_P         = 0;

  // Display-channel RAM window in external data space
  localparam logic [7:0]  DISP_WIN_HI   = 8'hFF;

  // Access kinds on the core request port
  localparam logic [1:0]  SP_DIRECT     = 2'h0;
  localparam logic [1:0]  SP_INDIRECT   = 2'h1;
  localparam logic [1:0]  SP_REGISTER   = 2'h2;
  localparam logic [1:0]  SP_BIT        = 2'h3;

endpackage : ccr_pkg

// *** ccr_ram.sv ***
// Small single-write, single-read RAM with registered read data.
// Assumes write and read addresses are stable at the rising edge.
`timescale 1ns/1ps
module ccr_ram #(
  parameter int AW = 8                         // Address width
) (
  input  wire logic          i_clk_sys,        // System clock
  input  wire logic          i_we,             // Write enable
  input  wire logic [AW-1:0] i_waddr,          // Write address
  input  wire logic [7:0]    i_wdata,          // Write data
  input  wire logic [AW-1:0] i_raddr,          // Read address
  output logic      [7:0]    o_rdata           // Read data, one cycle late
);

  logic [7:0] mem [0:(1<<AW)-1];

  always_ff @(posedge i_clk_sys) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
    o_rdata <= mem[i_raddr];
  end

endmodule : ccr_ram

// *** ccr_xmem_model.sv ***
// External data memory seen by the core: keeps the last byte written.
// Assumes one-cycle request strobes; the upper half of the space is flash.
`timescale 1ns/1ps
module ccr_xmem_model (
  input  wire logic        i_clk_sys, // System clock
  input  wire logic        i_req,     // Request strobe
  input  wire logic        i_wr,      // Write
  input  wire logic [7:0]  i_wdata,   // Held write data
  input  wire logic [15:0] i_dec,     // Request address to decode
  output logic             o_flash,   // Target is flash
  output logic      [7:0]  o_last     // Last byte stored
);
  assign o_flash = i_dec[15];
  initial o_last = 8'h00;
  always @(posedge i_clk_sys) begin
    if (i_req && i_wr) begin
      o_last <= i_wdata;
    end
  end
endmodule : ccr_xmem_model
